// >>> src/opp_pkg.sv
// =====================================================================
// One-time PROM programming port: shared constants
// =====================================================================
// Holds the memory geometry, mode strap levels and programming timings.
// Assumes a 200 MHz clock on both ends of the programming link.
package opp_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int PROM_BYTES = 8192;
    localparam int RAM_BYTES = 256;
    localparam logic [15:0] MCU_BASE = 16'hE000;
    localparam logic [15:0] PROM_BASE = 16'h0000;
    localparam logic [15:0] PROM_LAST = 16'h1FFF;
    localparam logic [15:0] HALF_START = 16'h1000;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [7:0] ERASED_RESET = 8'hFF;
    localparam int CLK_MHZ = 200;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int MAX_TRIES = 25;
    localparam int SETTLE_CYC = 4;
    localparam logic STRAP_HIGH = 1'b1;
    localparam logic RESET_STRAP = 1'b0;
    localparam logic TEST_PROG = 1'b1;
endpackage

// >>> src/opp_link_if.sv
// =====================================================================
// Programming link between programmer and device
// =====================================================================
// Carries strap, address, strobe and data pins; resolves the data bus.
// Assumes both ends share one clock; enables are active low.
interface opp_link_if;
    logic test_vpp;
    logic reset_pin;
    logic [1:0] high_strap_pins;
    logic [12:0] addr;
    logic top_address_bit;
    logic ce_n;
    logic oe_n;
    logic write_strobe_in_n;
    logic oscillator_in_pin;
    logic oscillator_out_pin;
    logic [7:0] prog_data_o;
    logic prog_data_oe_n;
    logic [7:0] dev_data_o;
    logic dev_data_oe_n;
    logic [7:0] prom_data_bus;
    // Wire level of the shared data bus, programmer winning on a clash
    assign prom_data_bus = !prog_data_oe_n ? prog_data_o :
                           (!dev_data_oe_n ? dev_data_o : 8'hFF);
    modport device (input test_vpp, reset_pin, high_strap_pins, addr, top_address_bit,
                    ce_n, oe_n, write_strobe_in_n, oscillator_in_pin, prom_data_bus,
                    output oscillator_out_pin, dev_data_o, dev_data_oe_n);
    modport programmer (output test_vpp, reset_pin, high_strap_pins, addr,
                        top_address_bit, ce_n, oe_n, write_strobe_in_n,
                        oscillator_in_pin, prog_data_o, prog_data_oe_n,
                        input prom_data_bus, oscillator_out_pin);
endinterface

// >>> src/opp_device.sv
// =====================================================================
// Device end: one-time PROM array with programming and MCU access
// =====================================================================
// Holds the 8 KB PROM and 256-byte data RAM as flip-flops.
// Assumes pins are asynchronous and pass three-stage synchronisers.

// Notes on behaviour
// - Test pin held low gives processor mode
// - PROM at E000 in MCU, 0000 programming
// - Separate 256-byte static data memory
// - Programmer straps pins before any access
// - Strap pins high, reset low whole session
// - Address on address pins plus top bit; here all 13 bits go on addr, top bit is held low and not decoded
// - Data pins bidirectional: write in, verify out
// - Chip, output and program strobes control access
// - Clock into oscillator input, output open
// - One 0.1 ms strobe writes a byte
// - Verify after pulse, retry up to 25
// - On pass increment address by one
// - Final verify pass over all addresses; a half-image job verifies 1000-1FFF only
// - Unused locations FF or skipped
// - Relocate image before writing
// - No signature readout; never requested
module opp_device #(
    parameter int PROM_DEPTH = opp_pkg::PROM_BYTES,
    parameter int RAM_DEPTH = opp_pkg::RAM_BYTES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Programming link
    opp_link_if.device link,
    // Processor side bus
    input wire logic [15:0] cpu_addr,
    output logic [7:0] cpu_rom_data,
    input wire logic [7:0] cpu_ram_addr,
    input wire logic cpu_ram_we,
    input wire logic [7:0] cpu_ram_wdata,
    output logic [7:0] cpu_ram_rdata,
    output logic prom_mode
);
    localparam int SYNC_W = 5 + 13 + 1 + 8;
    // Idle pin levels, so leaving reset shows no false strobe or enable edge
    localparam logic [SYNC_W-1:0] PIN_IDLE = {3'b000, 2'b11, 13'h0000, 1'b1, 8'hFF};
    logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
    logic [SYNC_W-1:0] s1_next, s2_next, s3_next;
    logic [SYNC_W-1:0] stable_reg, stable_next;
    // Erased state at power-up is all ones; the array is never reset
    logic [7:0] prom_mem [PROM_DEPTH] = '{default: opp_pkg::ERASED_RESET};
    logic [7:0] ram_mem [RAM_DEPTH] = '{default: 8'h00};
    logic [7:0] dout_reg, dout_next;
    logic drive_reg, drive_next;
    logic wr_arm_reg, wr_arm_next;
    logic [7:0] rom_reg, rom_next;
    logic [7:0] ramq_reg, ramq_next;
    logic mode_ok, ce_a, oe_a, pgm_a;
    logic [12:0] paddr;
    logic [7:0] pdata;

    // Pack raw pin levels for the synchroniser chain
    logic [SYNC_W-1:0] raw;
    assign raw = {link.test_vpp, link.reset_pin, link.high_strap_pins[0], link.ce_n,
                  link.oe_n, link.addr, link.write_strobe_in_n, link.prom_data_bus};

    // =================================================================
    // Pin synchronisers: a bit changes once stages two and three agree
    // =================================================================
    always_comb begin
        s1_next = raw;
        s2_next = s1_reg;
        s3_next = s2_reg;
        stable_next = stable_reg;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                stable_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= PIN_IDLE;
            s2_reg <= PIN_IDLE;
            s3_reg <= PIN_IDLE;
            stable_reg <= PIN_IDLE;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            stable_reg <= stable_next;
        end
    end

    // Decode synchronised pins; strap pin 1 is not decoded here, only checked by the link checker
    assign mode_ok = stable_reg[26] == opp_pkg::TEST_PROG
                     && stable_reg[25] == opp_pkg::RESET_STRAP
                     && stable_reg[24] == opp_pkg::STRAP_HIGH;
    assign ce_a = !stable_reg[23];
    assign oe_a = !stable_reg[22];
    assign paddr = stable_reg[21:9];
    assign pgm_a = !stable_reg[8];
    assign pdata = stable_reg[7:0];
    assign prom_mode = mode_ok;

    // =================================================================
    // PROM array and access logic
    // =================================================================
    // A write fires once per strobe assertion; a one-time cell can only
    // clear bits, so the stored byte is ANDed with the incoming data.
    always_comb begin
        wr_arm_next = wr_arm_reg;
        dout_next = dout_reg;
        drive_next = 1'b0;
        rom_next = rom_reg;
        ramq_next = ram_mem[cpu_ram_addr];
        if (mode_ok) begin
            if (ce_a && pgm_a) begin
                wr_arm_next = 1'b0;
            end else begin
                wr_arm_next = 1'b1;
            end
            if (ce_a && oe_a && !pgm_a) begin
                dout_next = prom_mem[paddr];
                drive_next = 1'b1;
            end
        end else begin
            wr_arm_next = 1'b1;
            // MCU view: window E000-FFFF only, elsewhere blank
            if (cpu_addr >= opp_pkg::MCU_BASE) begin
                rom_next = prom_mem[cpu_addr[12:0]];
            end else begin
                rom_next = opp_pkg::BLANK_BYTE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_arm_reg <= 1'b1;
            dout_reg <= '0;
            drive_reg <= 1'b0;
            rom_reg <= '0;
            ramq_reg <= '0;
        end else begin
            wr_arm_reg <= wr_arm_next;
            dout_reg <= dout_next;
            drive_reg <= drive_next;
            rom_reg <= rom_next;
            ramq_reg <= ramq_next;
        end
    end

    // Storage arrays, kept outside reset-value logic for size
    always_ff @(posedge clk) begin
        if (mode_ok && ce_a && pgm_a && wr_arm_reg) begin
            prom_mem[paddr] <= prom_mem[paddr] & pdata;
        end
        if (!mode_ok && cpu_ram_we) begin
            ram_mem[cpu_ram_addr] <= cpu_ram_wdata;
        end
    end

    // Outputs; enable low while driving, oscillator output left quiet
    assign link.dev_data_o = dout_reg;
    assign link.dev_data_oe_n = !drive_reg;
    assign link.oscillator_out_pin = 1'b0;
    assign cpu_rom_data = rom_reg;
    assign cpu_ram_rdata = ramq_reg;
    // No signature path exists: address pin 9 has no special meaning
endmodule

// >>> src/opp_programmer.sv
// =====================================================================
// Programmer end: fast-program loop with verify and final pass
// =====================================================================
// Walks a range of PROM addresses pulsing, verifying and retrying.
// Assumes the device samples pins through multi-stage synchronisers.
module opp_programmer #(
    parameter int PULSE_CYCLES = opp_pkg::PULSE_CYC,
    parameter int TRIES = opp_pkg::MAX_TRIES,
    parameter int SETTLE = opp_pkg::SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Programming link
    opp_link_if.programmer link,
    // Job control
    input wire logic start,
    input wire logic half_image,
    output logic [12:0] img_addr,
    input wire logic [7:0] img_data,
    output logic busy,
    output logic done,
    output logic fail
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001, ST_SETUP = 7'b0000010, ST_PULSE = 7'b0000100,
        ST_GAP = 7'b0001000, ST_VERIFY = 7'b0010000, ST_FINAL = 7'b0100000,
        ST_END = 7'b1000000
    } opp_state_t;
    opp_state_t st_reg, st_next;
    logic [12:0] addr_reg, addr_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [5:0] try_reg, try_next;
    logic [7:0] wd_reg, wd_next;
    logic ce_reg, ce_next, oe_reg, oe_next, pgm_reg, pgm_next, drv_reg, drv_next;
    logic done_reg, done_next, fail_reg, fail_next, final_reg, final_next;

    // Expected byte is the image byte unchanged; no blank substitution is made
    function automatic logic [7:0] want(input logic [7:0] d);
        return d;
    endfunction

    // =================================================================
    // Sequencer
    // =================================================================
    always_comb begin
        st_next = st_reg;
        addr_next = addr_reg;
        cnt_next = cnt_reg + 32'd1;
        try_next = try_reg;
        wd_next = wd_reg;
        ce_next = ce_reg;
        oe_next = oe_reg;
        pgm_next = pgm_reg;
        drv_next = drv_reg;
        done_next = done_reg;
        fail_next = fail_reg;
        final_next = final_reg;
        case (st_reg)
            ST_IDLE: begin
                cnt_next = '0;
                if (start) begin
                    // 4 KB images start half way up
                    addr_next = half_image ? opp_pkg::HALF_START[12:0] :
                                             opp_pkg::PROM_BASE[12:0];
                    try_next = '0;
                    done_next = 1'b0;
                    fail_next = 1'b0;
                    final_next = 1'b0;
                    st_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                ce_next = 1'b1;
                oe_next = 1'b0;
                drv_next = !final_reg;
                wd_next = want(img_data);
                if (cnt_reg >= 32'(SETTLE)) begin
                    cnt_next = '0;
                    st_next = final_reg ? ST_GAP : ST_PULSE;
                end
            end
            ST_PULSE: begin
                pgm_next = 1'b1;
                if (cnt_reg >= 32'(PULSE_CYCLES)) begin
                    pgm_next = 1'b0;
                    cnt_next = '0;
                    try_next = try_reg + 6'd1;
                    st_next = ST_GAP;
                end
            end
            ST_GAP: begin
                drv_next = 1'b0;
                oe_next = 1'b1;
                if (cnt_reg >= 32'(2 * SETTLE)) begin
                    cnt_next = '0;
                    st_next = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                cnt_next = '0;
                oe_next = 1'b0;
                if (link.prom_data_bus == wd_reg) begin
                    try_next = '0;
                    if (addr_reg == opp_pkg::PROM_LAST[12:0]) begin
                        if (final_reg) begin
                            done_next = 1'b1;
                            st_next = ST_END;
                        end else begin
                            st_next = ST_FINAL;
                        end
                    end else begin
                        addr_next = addr_reg + 13'd1;
                        st_next = ST_SETUP;
                    end
                end else if (final_reg || try_reg >= 6'(TRIES)) begin
                    fail_next = 1'b1;
                    st_next = ST_END;
                end else begin
                    st_next = ST_SETUP;
                end
            end
            ST_FINAL: begin
                // Second pass reads only, with the supply pin still held high
                final_next = 1'b1;
                addr_next = half_image ? opp_pkg::HALF_START[12:0] :
                                         opp_pkg::PROM_BASE[12:0];
                cnt_next = '0;
                st_next = ST_SETUP;
            end
            ST_END: begin
                ce_next = 1'b0;
                oe_next = 1'b0;
                drv_next = 1'b0;
                if (!start) begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            addr_reg <= '0;
            cnt_reg <= '0;
            try_reg <= '0;
            wd_reg <= '0;
            ce_reg <= 1'b0;
            oe_reg <= 1'b0;
            pgm_reg <= 1'b0;
            drv_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            final_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            addr_reg <= addr_next;
            cnt_reg <= cnt_next;
            try_reg <= try_next;
            wd_reg <= wd_next;
            ce_reg <= ce_next;
            oe_reg <= oe_next;
            pgm_reg <= pgm_next;
            drv_reg <= drv_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            final_reg <= final_next;
        end
    end

    // Straps held for the whole session; supply pin also held high throughout
    assign link.test_vpp = 1'b1;
    assign link.reset_pin = opp_pkg::RESET_STRAP;
    assign link.high_strap_pins = {2{opp_pkg::STRAP_HIGH}};
    assign link.addr = addr_reg;
    assign link.top_address_bit = 1'b0;
    assign link.ce_n = !ce_reg;
    assign link.oe_n = !oe_reg;
    assign link.write_strobe_in_n = !pgm_reg;
    assign link.oscillator_in_pin = clk;
    assign link.prog_data_o = wd_reg;
    assign link.prog_data_oe_n = !drv_reg;
    // Part type is fixed; no signature read is ever issued
    assign img_addr = addr_reg;
    assign busy = st_reg != ST_IDLE && st_reg != ST_END;
    assign done = done_reg;
    assign fail = fail_reg;
endmodule

// >>> tb/opp_link_asserts.sv
// =====================================================================
// Programming link checker
// =====================================================================
// Concurrent checks on the link between programmer and device ends.
// Assumes one clock for both ends and an active-low asynchronous reset.
module opp_link_asserts #(
    parameter int PULSE_CYCLES = opp_pkg::PULSE_CYC,
    parameter int TRIES = opp_pkg::MAX_TRIES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode straps
    input wire logic test_vpp,
    input wire logic reset_pin,
    input wire logic [1:0] high_strap_pins,
    // Address and strobes
    input wire logic [12:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic write_strobe_in_n,
    // Data enables
    input wire logic prog_data_oe_n,
    input wire logic dev_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] low_cnt_reg, low_cnt_next;
    logic [12:0] last_addr_reg, last_addr_next;
    logic [5:0] tries_reg, tries_next;
    logic seen_reg, seen_next;
    logic ws_q_reg;
    logic pulse_fall;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // =================================================================
    // Helper counters
    // =================================================================
    // Strobe low time and pulses spent on one address
    assign pulse_fall = ws_q_reg && !write_strobe_in_n;
    always_comb begin
        low_cnt_next = write_strobe_in_n ? 16'h0000 : low_cnt_reg + 16'h0001;
        last_addr_next = pulse_fall ? addr : last_addr_reg;
        // A released chip enable ends a job; the next job may start anywhere
        seen_next = ce_n ? 1'b0 : (seen_reg | pulse_fall);
        tries_next = tries_reg;
        if (pulse_fall) begin
            tries_next = (seen_reg && addr == last_addr_reg) ? tries_reg + 6'h01 : 6'h01;
        end
    end
    // Registers only; counts restart with every reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= 16'h0000;
            last_addr_reg <= 13'h0000;
            tries_reg <= 6'h00;
            seen_reg <= 1'b0;
            ws_q_reg <= 1'b1;
        end else begin
            low_cnt_reg <= low_cnt_next;
            last_addr_reg <= last_addr_next;
            tries_reg <= tries_next;
            seen_reg <= seen_next;
            ws_q_reg <= write_strobe_in_n;
        end
    end

    // =================================================================
    // Assertions
    // =================================================================
    a_pulse_width: assert property ($rose(write_strobe_in_n) |-> low_cnt_reg == PULSE_CYCLES)
        else $error("strobe pulse length wrong");
    a_strobe_gated: assert property (!write_strobe_in_n |-> !ce_n && oe_n && !prog_data_oe_n)
        else $error("strobe without chip enable or with output enable");
    a_straps_held: assert property (!ce_n |-> test_vpp && !reset_pin && high_strap_pins == 2'b11)
        else $error("access while mode straps not set");
    a_addr_steady: assert property (!write_strobe_in_n |-> $stable(addr))
        else $error("address moved during pulse");
    a_addr_step: assert property (pulse_fall && seen_reg |->
        addr == last_addr_reg || addr == last_addr_reg + 13'h0001)
        else $error("address step other than one");
    a_retry_bound: assert property (tries_reg <= TRIES)
        else $error("too many pulses on one address");
    a_verify_read: assert property ($rose(write_strobe_in_n) |-> ##[1:20] (!oe_n && !ce_n))
        else $error("no verify read after pulse");
    a_read_drive: assert property ((!ce_n && !oe_n && write_strobe_in_n) [*6] |-> !dev_data_oe_n)
        else $error("device not driving on enabled read");
    a_idle_release: assert property ((ce_n || oe_n) [*8] |-> dev_data_oe_n)
        else $error("device driving outside read");

    // Main scenarios reached
    c_pulse: cover property ($rose(write_strobe_in_n));
    c_retry_limit: cover property (tries_reg == TRIES);
    c_read: cover property (!dev_data_oe_n);
endmodule

// >>> tb/testbench.sv
// =====================================================================
// Programming port testbench
// =====================================================================
// Programmer and device face each other on one link; a second device is
// driven by hand on a second link. Assumes a 200 MHz clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortest pulse and settle the synchronisers allow: a half-image job
    // then takes about 111k cycles, two passes of 4096 bytes
    localparam int PULSE = 2;
    localparam int SETTLE_SIM = 3;
    logic clk, rst_n, start, half_image, job2, mon_on, ws_q, oe_q, cpu_ram_we, busy, done, fail;
    logic prom_mode, got_d, got_f;
    logic [12:0] img_addr;
    logic [7:0] img_data, cpu_rom_data, cpu_ram_rdata, rd, cpu_ram_addr, cpu_ram_wdata;
    logic [15:0] cpu_addr;
    int num_errors, checks, n_pulse, n_read;
    opp_link_if link();
    opp_link_if link2();

    // Image pattern; the inverted form verifies over the first only where the low address byte is A5
    function automatic logic [7:0] img_fn(input logic [12:0] a, input logic inv);
        img_fn = inv ? ~(a[7:0] ^ 8'h5A) : (a[7:0] ^ 8'h5A);
    endfunction
    assign img_data = img_fn(img_addr, job2);
    assign link2.oscillator_in_pin = clk;

    opp_programmer #(.PULSE_CYCLES(PULSE), .SETTLE(SETTLE_SIM)) opp_programmer_i (.clk(clk),
        .rst_n(rst_n),
        .link(link), .start(start), .half_image(half_image), .img_addr(img_addr),
        .img_data(img_data), .busy(busy), .done(done), .fail(fail));
    opp_device opp_device_i (.clk(clk), .rst_n(rst_n), .link(link), .cpu_addr(cpu_addr),
        .cpu_rom_data(), .cpu_ram_addr(cpu_ram_addr), .cpu_ram_we(cpu_ram_we),
        .cpu_ram_wdata(cpu_ram_wdata), .cpu_ram_rdata(), .prom_mode());
    opp_device opp_device_i2 (.clk(clk), .rst_n(rst_n), .link(link2), .cpu_addr(cpu_addr),
        .cpu_rom_data(cpu_rom_data), .cpu_ram_addr(cpu_ram_addr), .cpu_ram_we(cpu_ram_we),
        .cpu_ram_wdata(cpu_ram_wdata), .cpu_ram_rdata(cpu_ram_rdata), .prom_mode(prom_mode));
    opp_link_asserts #(.PULSE_CYCLES(PULSE), .TRIES(opp_pkg::MAX_TRIES)) opp_link_asserts_i (
        .clk(clk), .rst_n(rst_n), .test_vpp(link.test_vpp), .reset_pin(link.reset_pin),
        .high_strap_pins(link.high_strap_pins), .addr(link.addr), .ce_n(link.ce_n),
        .oe_n(link.oe_n), .write_strobe_in_n(link.write_strobe_in_n),
        .prog_data_oe_n(link.prog_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n));

    // =================================================================
    // Shared tasks
    // =================================================================
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic end_sim;
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Strobe levels on the hand-driven link, then hold for n edges
    task automatic pins2(input logic ce, input logic oe, input logic ws, input int n);
        @(posedge clk);
        link2.ce_n <= ce;
        link2.oe_n <= oe;
        link2.write_strobe_in_n <= ws;
        repeat (n) @(posedge clk);
    endtask
    task automatic wr2(input logic [12:0] a, input logic [7:0] d, input logic ce);
        @(posedge clk);
        link2.addr <= a;
        link2.prog_data_o <= d;
        link2.prog_data_oe_n <= 1'b0;
        pins2(ce, 1'b1, 1'b1, 6);
        pins2(ce, 1'b1, 1'b0, 8);
        pins2(ce, 1'b1, 1'b1, 6);
        link2.prog_data_oe_n <= 1'b1;
        pins2(1'b1, 1'b1, 1'b1, 2);
    endtask
    task automatic rd2(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk);
        link2.addr <= a;
        pins2(1'b0, 1'b0, 1'b1, 12);
        d = link2.prom_data_bus;
        pins2(1'b1, 1'b1, 1'b1, 8);
    endtask
    // One programmer job over the upper half; waits bounded for its end
    task automatic run_job(input logic inv, output logic d, output logic f);
        int i;
        @(posedge clk);
        job2 <= inv;
        half_image <= 1'b1;
        mon_on <= 1'b1;
        start <= 1'b1;
        n_pulse = 0;
        n_read = 0;
        repeat (3) @(posedge clk);
        chk("busy", 16'h0001, {15'h0, busy});
        for (i = 0; i < 115000 && done !== 1'b1 && fail !== 1'b1; i++) @(posedge clk);
        d = done;
        f = fail;
        mon_on <= 1'b0;
        start <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Watches every pulse and read on the programmer link during a job
    always @(posedge clk) begin
        ws_q <= link.write_strobe_in_n;
        oe_q <= link.oe_n;
        if (mon_on && ws_q && !link.write_strobe_in_n) begin
            chk("pulse addr", job2 ? 16'h1000 : 16'h1000 + 16'(n_pulse), {3'h0, link.addr});
            chk("pulse data", {8'h00, img_fn(link.addr, job2)}, {8'h00, link.prom_data_bus});
            n_pulse++;
        end
        if (mon_on && oe_q && !link.oe_n) begin
            n_read++;
        end
        if (mon_on && !link.ce_n && link.addr < 13'h1000) begin
            chk("unused area access", 16'h1000, {3'h0, link.addr});
        end
    end

    // =================================================================
    // Scenarios
    // =================================================================
    task automatic t_reset;
        chk("dev oe_n", 16'h0001, {15'h0, link.dev_data_oe_n});
        chk("strobe idle", 16'h0001, {15'h0, link.write_strobe_in_n});
        chk("osc out", 16'h0000, {15'h0, link.oscillator_out_pin});
    endtask
    task automatic t_direct;
        wr2(13'h0123, 8'h3C, 1'b0);
        rd2(13'h0123, rd);
        chk("read 0123", 16'h003C, {8'h00, rd});
        wr2(13'h0124, 8'h00, 1'b1);
        rd2(13'h0124, rd);
        chk("read 0124", 16'h00FF, {8'h00, rd});
        chk("dev2 oe_n idle", 16'h0001, {15'h0, link2.dev_data_oe_n});
    endtask
    task automatic t_mcu;
        @(posedge clk);
        link2.test_vpp <= 1'b0;
        cpu_addr <= 16'hE123;
        repeat (10) @(posedge clk);
        chk("prom_mode", 16'h0000, {15'h0, prom_mode});
        chk("rom E123", 16'h003C, {8'h00, cpu_rom_data});
        cpu_addr <= 16'h0123;
        cpu_ram_addr <= 8'hFF;
        cpu_ram_wdata <= 8'h5A;
        cpu_ram_we <= 1'b1;
        @(posedge clk);
        cpu_ram_we <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rom 0123", 16'h00FF, {8'h00, cpu_rom_data});
        chk("ram FF", 16'h005A, {8'h00, cpu_ram_rdata});
    endtask
    task automatic t_program;
        run_job(1'b0, got_d, got_f);
        chk("job done", 16'h0001, {15'h0, got_d});
        chk("job fail", 16'h0000, {15'h0, got_f});
        chk("pulse count", 16'h1000, 16'(n_pulse));
        chk("read count", 16'h2000, 16'(n_read));
    endtask
    task automatic t_retry;
        run_job(1'b1, got_d, got_f);
        chk("retry fail", 16'h0001, {15'h0, got_f});
        chk("retry pulses", 16'(opp_pkg::MAX_TRIES), 16'(n_pulse));
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hung job cut short; 120k cycles covers both jobs and the direct tests
    initial begin
        #600000;
        num_errors++;
        end_sim();
    end
    // Main sequence
    initial begin
        {num_errors, checks} = 0;
        {rst_n, start, half_image, job2, mon_on, cpu_ram_we} = 6'h00;
        {ws_q, oe_q} = 2'b11;
        cpu_addr = 16'h0000;
        cpu_ram_addr = 8'h00;
        cpu_ram_wdata = 8'h00;
        link2.test_vpp = 1'b1;
        link2.reset_pin = 1'b0;
        link2.high_strap_pins = 2'b11;
        link2.addr = 13'h0000;
        link2.top_address_bit = 1'b0;
        {link2.ce_n, link2.oe_n, link2.write_strobe_in_n, link2.prog_data_oe_n} = 4'hF;
        link2.prog_data_o = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_direct();
        t_mcu();
        t_program();
        t_retry();
        end_sim();
    end
endmodule
